/* pkg/tppwm_pkg.sv */
// package for the three-phase pwm output stage: register map, field layout,
// reset values, bus carriers and the block's state record.
// assumes one core clock domain and a 32-bit apb register bus.
package tppwm_pkg;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [11:0] OFF_PERIOD  = 12'h000; // period_value
  localparam logic [11:0] OFF_DEAD    = 12'h004; // dead_time_value
  localparam logic [11:0] OFF_DUTY0   = 12'h008; // phase0_duty
  localparam logic [11:0] OFF_DUTY1   = 12'h00C; // phase1_duty
  localparam logic [11:0] OFF_DUTY2   = 12'h010; // phase2_duty
  localparam logic [11:0] OFF_OUTCTRL = 12'h014; // output_crossover_disable_ctrl
  localparam logic [11:0] OFF_CHOPCFG = 12'h018; // gate_drive_chop_cfg
  localparam logic [11:0] OFF_STATUS  = 12'h01C; // pwm_half_status
  localparam logic [11:0] OFF_MODE    = 12'h020; // update mode select

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int XOVER_P0_BIT  = 8;  // crossover phase 0, phase p at 8-p
  localparam int CHOP_HI_BIT   = 8;  // chop all high sides
  localparam int CHOP_LO_BIT   = 9;  // chop all low sides
  localparam int CHOP_DIV_LSB  = 0;  // chop_divider, 8 bits
  localparam int MODE_DBL_BIT  = 0;  // 1 = double update
  localparam int STAT_HALF_BIT = 0;  // 1 = second half of period
  localparam int STAT_RUN_BIT  = 1;  // main timer counting
  localparam int STAT_ACT_BIT  = 2;  // outputs live

  // ***************************************************************
  // reset values and counts
  // ***************************************************************
  localparam logic [8:0]  OUTCTRL_RST = 9'h000;  // no crossover, all enabled
  localparam logic [15:0] CHOPCFG_RST = 16'h0000;
  localparam logic [16:0] HALF_MIN    = 17'h00002; // shortest half, keeps sync a pulse

  // ***************************************************************
  // carriers and state
  // ***************************************************************
  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } tppwm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tppwm_apb_rsp_t;

  typedef struct packed {
    logic [15:0]      period;    // written period value
    logic [15:0]      dead;      // written dead time
    logic [2:0][15:0] duty;      // written duties
    logic [8:0]       outctrl;   // written output control
    logic [15:0]      chop;      // gate drive config
    logic             dbl;       // double update mode
    logic [3:0]       written;   // period, duty0..2 seen once
    logic [15:0]      s_period;  // values in force this half
    logic [15:0]      s_dead;
    logic [2:0][15:0] s_duty;
    logic [8:0]       s_outctrl;
    logic             run;       // main timer started
    logic             started;   // first sync issued
    logic [16:0]      start_cnt; // cycles to first sync
    logic             half;      // second half flag
    logic [16:0]      cnt;       // position in half
    logic             sync;      // cycle_sync_pulse
    logic [5:0]       pins;      // registered gate outputs
    logic [31:0]      prdata;    // read data latched at setup
    logic             err;       // setup address unmapped
  } tppwm_state_t;

  localparam tppwm_state_t STATE_RST = '0;

endpackage

/* hw/tppwm_chop.sv */
// chopping carrier for the gate drive unit.
// assumes the divider is stable between changes; a change takes
// effect at once, on the carrier level in progress.
`timescale 1ns/1ps
module tppwm_chop (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic [7:0] div,
  output logic            carrier
);
  import tppwm_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [8:0] cnt;   // cycles in current carrier half
    logic       level; // carrier level
  } tppwm_chop_t;

  tppwm_chop_t q;  // registered state
  tppwm_chop_t d;  // next state

  // each level lasts 2*(div+1) cycles, giving a 50 percent carrier
  always_comb begin
    d = q;
    // last cycle of this level flips the carrier
    if (q.cnt >= {div, 1'b1}) begin
      d.cnt   = 9'h000;
      d.level = !q.level;
    end else begin
      d.cnt = q.cnt + 9'h001;
    end
  end

  // register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign carrier = q.level;

  // carrier period is 4*(div+1): a level never outlasts its half
  chop_half_len_a: assert property (@(posedge clk) disable iff (reset || !ce)
    q.cnt <= {div, 1'b1} || $changed(div)) else $error("chop counter overran half");

endmodule

/* hw/tppwm_stage.sv */
// three-phase centre-aligned pwm output stage with apb registers.
// assumes one core clock; gate driver inputs are plain active-high outputs.
`timescale 1ns/1ps
module tppwm_stage (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      ce,
  input  wire tppwm_pkg::tppwm_apb_req_t apb_req,
  output tppwm_pkg::tppwm_apb_rsp_t      apb_rsp,
  output logic                           cycle_sync_pulse,
  output logic                           phase0_high_pin,
  output logic                           phase0_low_pin,
  output logic                           phase1_high_pin,
  output logic                           phase1_low_pin,
  output logic                           phase2_high_pin,
  output logic                           phase2_low_pin
);
  import tppwm_pkg::*;

  // ***************************************************************
  // helpers
  // ***************************************************************

  // on time within one half: hl/2 +/- duty - dead, clamped to [0, hl]
  // a dead time of at least half the half plus the side's signed duty simply holds that side off
  function automatic logic [16:0] on_time(input logic [16:0] hl,
                                          input logic [15:0] duty,
                                          input logic [15:0] dead,
                                          input logic        low_side);
    logic signed [19:0] dx;
    logic signed [19:0] v;
    dx = $signed({{4{duty[15]}}, duty});
    if (low_side) begin
      dx = -dx;
    end
    // dead time eats into both edges equally, pattern stays centred
    v = $signed({4'h0, hl[16:1]}) + dx - $signed({4'h0, dead});
    if (v < 20'sh00000) begin
      on_time = 17'h00000;
    end else if (v > $signed({3'b000, hl})) begin
      on_time = hl;
    end else begin
      on_time = v[16:0];
    end
  endfunction

  // ***************************************************************
  // state and combinational terms
  // ***************************************************************
  tppwm_state_t q;          // registered state
  tppwm_state_t d;          // next state
  logic         carrier;    // chop carrier
  logic [16:0]  hl;         // length of current half in cycles
  logic         active;     // outputs may switch
  logic         setup;      // apb setup cycle
  logic         access;     // apb access cycle
  logic         wr;         // write takes effect now
  logic         reload;     // sync edge: latch shadows
  logic [2:0]   tim_h;      // timing unit high sides
  logic [2:0]   tim_l;      // timing unit low sides
  logic [5:0]   pv;         // pin vector, bit k disabled by outctrl[k]
  logic [16:0]  on_h [3];   // high on time per half
  logic [16:0]  on_l [3];   // low on time per half

  // ***************************************************************
  // chop carrier
  // ***************************************************************
  tppwm_chop u_chop (
    .clk     (clk),
    .reset   (reset),
    .ce      (ce),
    .div     (q.chop[CHOP_DIV_LSB +: 8]),
    .carrier (carrier)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    d      = q;
    reload = 1'b0;
    setup  = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable;
    wr     = access && apb_req.pwrite && !q.err;
    active = q.started && (&q.written);

    // half length; double update gives each half its own full value
    if (q.dbl) begin
      hl = {1'b0, q.s_period};
    end else begin
      hl = {2'b00, q.s_period[15:1]};
    end
    // a one-cycle half would merge sync pulses in double update
    if (hl < HALF_MIN) begin
      hl = HALF_MIN;
    end

    // ---- main timer: start-up delay, then halves ----
    // the start delay only runs once, from the first period write
    d.sync = 1'b0;
    if (q.run && !q.started) begin
      if (q.start_cnt <= 17'h00001) begin
        d.started = 1'b1;
        d.sync    = 1'b1;
        d.half    = 1'b0;
        d.cnt     = 17'h00000;
        reload    = 1'b1;
      end else begin
        d.start_cnt = q.start_cnt - 17'h00001;
      end
    end else if (q.started) begin
      if (q.cnt >= hl - 17'h00001) begin
        d.cnt  = 17'h00000;
        d.half = !q.half;
        // midpoint sync only in double update
        if (q.half || q.dbl) begin
          d.sync = 1'b1;
          reload = 1'b1;
        end
      end else begin
        d.cnt = q.cnt + 17'h00001;
      end
    end

    // ---- latch values in force on the sync edge ----
    // shadows keep each half self-consistent while software rewrites
    if (reload) begin
      d.s_period  = q.period;
      d.s_dead    = q.dead;
      d.s_duty    = q.duty;
      d.s_outctrl = q.outctrl;
    end

    // ---- timing unit, same rules for every phase ----
    for (int p = 0; p < 3; p++) begin
      on_h[p] = on_time(hl, q.s_duty[p], q.s_dead, 1'b0);
      on_l[p] = on_time(hl, q.s_duty[p], q.s_dead, 1'b1);
      // first half switches on late, second half switches off early
      tim_h[p] = q.half ? (q.cnt < on_h[p]) : (q.cnt >= hl - on_h[p]);
      tim_l[p] = q.half ? (q.cnt < on_l[p]) : (q.cnt >= hl - on_l[p]);
    end

    // ---- output control: crossover, chop, then disable ----
    for (int p = 0; p < 3; p++) begin
      // crossover bit for phase p sits at 8-p
      if (q.s_outctrl[XOVER_P0_BIT - p]) begin
        pv[4 - 2 * p] = tim_l[p];
        pv[5 - 2 * p] = tim_h[p];
      end else begin
        pv[4 - 2 * p] = tim_h[p];
        pv[5 - 2 * p] = tim_l[p];
      end
      // carrier gates only the on time, off stays low
      pv[4 - 2 * p] = pv[4 - 2 * p] && (carrier || !q.chop[CHOP_HI_BIT]);
      pv[5 - 2 * p] = pv[5 - 2 * p] && (carrier || !q.chop[CHOP_LO_BIT]);
    end
    // pins are registered: one cycle of delay buys glitch-free gate drive
    // disable acts on the physical pin, after swapping
    d.pins = pv & ~q.s_outctrl[5:0] & {6{active}};

    // ---- apb: decode and read at setup ----
    // read data is latched a cycle early so prdata comes from a flop
    if (setup) begin
      d.err    = 1'b0;
      d.prdata = 32'h00000000;
      unique case (apb_req.paddr)
        OFF_PERIOD:  d.prdata[15:0] = q.period;
        OFF_DEAD:    d.prdata[15:0] = q.dead;
        OFF_DUTY0:   d.prdata[15:0] = q.duty[0];
        OFF_DUTY1:   d.prdata[15:0] = q.duty[1];
        OFF_DUTY2:   d.prdata[15:0] = q.duty[2];
        OFF_OUTCTRL: d.prdata[8:0]  = q.outctrl;
        OFF_CHOPCFG: d.prdata[15:0] = q.chop;
        OFF_MODE:    d.prdata[MODE_DBL_BIT] = q.dbl;
        OFF_STATUS: begin
          d.prdata[STAT_HALF_BIT] = q.half;
          d.prdata[STAT_RUN_BIT]  = q.run;
          d.prdata[STAT_ACT_BIT]  = active;
        end
        default:     d.err = 1'b1; // unmapped: slave error
      endcase
    end

    // ---- apb: writes land at the access edge ----
    // duty, dead and period reach the halves only through the shadows; the first period write sets the start delay directly
    if (wr) begin
      unique case (apb_req.paddr)
        OFF_PERIOD: begin
          d.period     = apb_req.pwdata[15:0];
          d.written[0] = 1'b1;
          // only the first write starts the timer
          if (!q.run) begin
            d.run = 1'b1;
            if (q.dbl) begin
              d.start_cnt = {1'b0, apb_req.pwdata[15:0]};
            end else begin
              d.start_cnt = {1'b0, apb_req.pwdata[15:0]} + {2'b00, apb_req.pwdata[15:1]};
            end
          end
        end
        OFF_DEAD:    d.dead = apb_req.pwdata[15:0];
        OFF_DUTY0: begin
          d.duty[0]    = apb_req.pwdata[15:0];
          d.written[1] = 1'b1;
        end
        OFF_DUTY1: begin
          d.duty[1]    = apb_req.pwdata[15:0];
          d.written[2] = 1'b1;
        end
        OFF_DUTY2: begin
          d.duty[2]    = apb_req.pwdata[15:0];
          d.written[3] = 1'b1;
        end
        OFF_OUTCTRL: d.outctrl = apb_req.pwdata[8:0];
        OFF_CHOPCFG: d.chop = apb_req.pwdata[15:0];
        OFF_MODE:    d.dbl = apb_req.pwdata[MODE_DBL_BIT];
        default:     d.err = q.err; // status is read only
      endcase
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // reset clears crossover and disable controls with everything else
  // ce low holds every field, so the timer and carrier simply pause
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= STATE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // pready is combinational so the access phase lasts one cycle while ce is high
  // pslverr rides on pready; its flag was latched in the setup cycle
  assign apb_rsp.prdata   = q.prdata;
  assign apb_rsp.pready   = access && ce;
  assign apb_rsp.pslverr  = access && ce && q.err;
  assign cycle_sync_pulse = q.sync;
  assign phase0_high_pin  = q.pins[4];
  assign phase0_low_pin   = q.pins[5];
  assign phase1_high_pin  = q.pins[2];
  assign phase1_low_pin   = q.pins[3];
  assign phase2_high_pin  = q.pins[0];
  assign phase2_low_pin   = q.pins[1];

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset || !ce);
  // output control checks below watch s_outctrl; the reset and sync-latch checks also read the written outctrl; chop checks use q.chop, which has no shadow

  outputs_held_off_a: assert property (!(&q.written) |-> q.pins == 6'h00)
    else $error("pwm output live before all registers written");

  period_starts_timer_a: assert property (wr && apb_req.paddr == OFF_PERIOD |=> q.run)
    else $error("period write did not start timer");

  first_sync_dbl_a: assert property (wr && apb_req.paddr == OFF_PERIOD && !q.run && q.dbl
    |=> q.start_cnt == {1'b0, $past(apb_req.pwdata[15:0])})
    else $error("double update start delay wrong");

  first_sync_single_a: assert property (wr && apb_req.paddr == OFF_PERIOD && !q.run && !q.dbl
    |=> q.start_cnt == {1'b0, $past(apb_req.pwdata[15:0])} + {2'b00, $past(apb_req.pwdata[15:1])})
    else $error("single update start delay wrong");

  disable_forces_off_a: assert property (q.s_outctrl[0] |=> !phase2_high_pin)
    else $error("disabled output switched on");

  ctrl_latched_sync_a: assert property (q.sync |-> q.s_outctrl == $past(q.outctrl))
    else $error("output control not latched on sync");

  sync_single_pulse_a: assert property (q.sync |=> !q.sync)
    else $error("sync pulse longer than one cycle");

  on_time_clamp_a: assert property (on_h[0] <= hl && on_l[0] <= hl)
    else $error("on time outside period");

  high_chop_gate_a: assert property (q.chop[CHOP_HI_BIT] && !carrier |=> !phase0_high_pin)
    else $error("chopped high side on while carrier low");

  half_toggle_a: assert property (q.started && q.cnt >= hl - 17'h00001 |=> q.half != $past(q.half))
    else $error("half flag did not toggle at end of half");

  // ---- output path and timer sequencing ----
  // reset wins over ce, so this one is never disabled
  reset_clears_ctrl_a: assert property (@(posedge clk) disable iff (1'b0) reset
    |=> q.outctrl == OUTCTRL_RST && q.s_outctrl == OUTCTRL_RST && q.chop == CHOPCFG_RST)
    else $error("reset left output control or chop config set");

  // start delay ran out: first sync and start together
  first_sync_due_a: assert property (q.run && !q.started && q.start_cnt <= 17'h00001
    |=> q.sync && q.started)
    else $error("first sync not issued when start delay ran out");

  // double update: every half ends in a sync
  dbl_mid_sync_a: assert property (q.started && q.dbl && q.cnt >= hl - 17'h00001 |=> q.sync)
    else $error("double update half ended without sync");

  // single update: no sync at the midpoint
  single_no_mid_a: assert property (q.started && !q.dbl && !q.half && q.cnt >= hl - 17'h00001
    |=> !q.sync)
    else $error("single update issued a midpoint sync");

  // crossed pair: low pin carries the high-side timing
  cross_low_feed_a: assert property (q.s_outctrl[XOVER_P0_BIT] && !q.s_outctrl[5] && !q.chop[CHOP_LO_BIT]
    && active |=> phase0_low_pin == $past(tim_h[0]))
    else $error("crossed low pin not fed by high-side timing");

  // straight pair: high pin carries the high-side timing
  straight_high_feed_a: assert property (!q.s_outctrl[XOVER_P0_BIT] && !q.s_outctrl[4] && !q.chop[CHOP_HI_BIT]
    && active |=> phase0_high_pin == $past(tim_h[0]))
    else $error("uncrossed high pin not fed by high-side timing");

  // disable bit follows the physical pin after the swap
  swap_then_off_a: assert property (q.s_outctrl[XOVER_P0_BIT - 1] && q.s_outctrl[2] |=> !phase1_high_pin)
    else $error("disable bit missed the swapped high pin");

  // low-side chop: carrier low forces the pin off
  low_chop_gate_a: assert property (q.chop[CHOP_LO_BIT] && !carrier |=> !phase1_low_pin)
    else $error("chopped low side on while carrier low");

endmodule

/* verif/tppwm_gate_model.sv */
// gate driver side of the pwm stage: watches the six gate inputs.
// assumes the sync pulse marks each timing interval; counts are per interval.
`timescale 1ns/1ps
module tppwm_gate_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sync,
  input  wire logic [5:0] pins,
  output logic [15:0]     len,
  output logic [5:0][7:0] hi,
  output logic [5:0][7:0] rise
);
  // ***************************************************************
  // interval counters
  // ***************************************************************
  logic [15:0]      run_q;  // cycles since last sync
  logic [5:0][7:0]  acc_h;  // on cycles this interval
  logic [5:0][7:0]  acc_r;  // rising edges this interval
  logic [5:0]       prev_q; // pins one cycle ago

  // a driver only sees levels, so on time and edges are all it can report
  always_ff @(posedge clk) begin
    if (reset) begin
      run_q  <= '0;
      acc_h  <= '0;
      acc_r  <= '0;
      prev_q <= '0;
      len    <= '0;
      hi     <= '0;
      rise   <= '0;
    end else begin
      prev_q <= pins;
      // interval closes on sync, this cycle still counted
      if (sync) begin
        len   <= run_q + 16'h0001;
        run_q <= '0;
      end else begin
        run_q <= run_q + 16'h0001;
      end
      for (int i = 0; i < 6; i++) begin
        if (sync) begin
          hi[i]    <= acc_h[i] + 8'(pins[i]);
          rise[i]  <= acc_r[i] + 8'(pins[i] & ~prev_q[i]);
          acc_h[i] <= '0;
          acc_r[i] <= '0;
        end else begin
          acc_h[i] <= acc_h[i] + 8'(pins[i]);
          acc_r[i] <= acc_r[i] + 8'(pins[i] & ~prev_q[i]);
        end
      end
    end
  end
endmodule

/* verif/tb.sv */
// self-checking bench for the three-phase pwm stage over apb.
// assumes a 100 MHz core clock and zero-wait apb answers.
`timescale 1ns/1ps
module tb;
  import tppwm_pkg::*;
  logic            clk;       // core clock
  logic            reset;     // sync reset
  logic            ce;        // clock enable, held high
  tppwm_apb_req_t  req;       // bus request
  tppwm_apb_rsp_t  rsp;       // bus answer
  logic            sync;      // cycle_sync_pulse
  logic            h0, l0, h1, l1, h2, l2;
  logic [15:0]     len;       // cycles between syncs
  logic [5:0][7:0] hi;        // on cycles per pin
  logic [5:0][7:0] rise;      // rising edges per pin
  logic [31:0]     rd;        // last read data
  logic [31:0]     r1;        // first status sample
  logic            er;        // last slave error
  time             t0;        // start of a timed wait
  int              failures;
  int              cmp_count;

  // ***************************************************************
  // design and driver model
  // ***************************************************************
  tppwm_stage DUT (.clk(clk), .reset(reset), .ce(ce), .apb_req(req), .apb_rsp(rsp),
    .cycle_sync_pulse(sync), .phase0_high_pin(h0), .phase0_low_pin(l0), .phase1_high_pin(h1),
    .phase1_low_pin(l1), .phase2_high_pin(h2), .phase2_low_pin(l2));
  tppwm_gate_model gdm (.clk(clk), .reset(reset), .sync(sync), .pins({l2, h2, l1, h1, l0, h0}),
    .len(len), .hi(hi), .rise(rise));

  // ***************************************************************
  // tasks
  // ***************************************************************
  // verdict and end of run, shared by tests and watchdog
  task stop_test;
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // value compare, four-state exact
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready seen at an edge
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.paddr   <= a;
    req.pwrite  <= w;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    // no answer at all: give up rather than hang
    if (n >= 50) begin
      failures++;
      stop_test;
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h00000000);
    chk(rd, exp);
  endtask

  // wait for n sync pulses, bounded; then let the model's latch land
  task wsync(input int n);
    int k;
    k = 0;
    while (n > 0) begin
      @(posedge clk);
      k++;
      if (sync === 1'b1) n--;
      if (k > 3000) begin
        failures++;
        stop_test;
      end
    end
    #1;
  endtask

  // on-cycle counts of all six pins, packed {2L,2H,1L,1H,0L,0H}
  task chkhi(input logic [5:0][7:0] e);
    for (int i = 0; i < 6; i++) begin
      chk(32'(hi[i]), 32'(e[i]));
    end
  endtask

  // ***************************************************************
  // clock, watchdog, tests
  // ***************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the tests need under 2000 cycles; 10000 means a hang
  initial begin
    #100000;
    failures++;
    stop_test;
  end

  initial begin
    failures  = 0;
    cmp_count = 0;
    ce        = 1'b1;
    reset     = 1'b1;
    req       = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // reset values and an unmapped place
    rdchk(OFF_OUTCTRL, 32'h00000000);
    rdchk(OFF_CHOPCFG, 32'h00000000);
    wr(12'h040, 32'h0000FFFF);
    chk(32'(er), 32'h00000001);
    xfer(12'h040, 1'b0, 32'h00000000);
    chk({rd[31:1], er}, 32'h00000001);
    // single update start-up, period written first
    wr(OFF_MODE, 32'h00000000);
    wr(OFF_PERIOD, 32'h00000008);
    t0 = $time;
    wr(OFF_DUTY0, 32'h00000000);
    wr(OFF_DUTY1, 32'h00000000);
    chk(32'({l2, h2, l1, h1, l0, h0}), 32'h00000000);
    wr(OFF_DUTY2, 32'h00000000);
    wsync(1);
    // 12 cycles to sync, one edge to see it, then the 1 ns settle
    chk(32'($time - t0), 32'h00000083);
    wsync(2);
    chk(32'(len), 32'h00000008);
    chkhi(48'h040404040404);
    // clamping both ways and dead time
    wr(OFF_DEAD, 32'h00000001);
    wr(OFF_DUTY0, 32'h00000010);
    wr(OFF_DUTY1, 32'h0000FFF0);
    wsync(2);
    chkhi(48'h020208000008);
    // crossover on 0 and 1, disable 1H after swap, phase 2 off
    wr(OFF_OUTCTRL, 32'h00000187);
    rdchk(OFF_OUTCTRL, 32'h00000187);
    wsync(2);
    chkhi(48'h000000000800);
    // high-side chop, divider 0: carrier period 4
    wr(OFF_OUTCTRL, 32'h00000000);
    wr(OFF_CHOPCFG, 32'h00000100);
    wsync(2);
    chk(32'(hi[0]), 32'h00000004);
    chk(32'(rise[0]), 32'h00000002);
    chk(32'(hi[3]), 32'h00000008);
    // low-side chop, divider 1: carrier period 8
    wr(OFF_CHOPCFG, 32'h00000201);
    rdchk(OFF_CHOPCFG, 32'h00000201);
    wsync(2);
    chk(32'(hi[3]), 32'h00000004);
    chk(32'(rise[3]), 32'h00000001);
    chk(32'(hi[0]), 32'h00000008);
    // mid-run reset clears the output control register
    wr(OFF_OUTCTRL, 32'h000001FF);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rdchk(OFF_OUTCTRL, 32'h00000000);
    // double update start-up and half periods
    wr(OFF_MODE, 32'h00000001);
    wr(OFF_DUTY0, 32'h00000000);
    wr(OFF_DUTY1, 32'h00000000);
    wr(OFF_DUTY2, 32'h00000000);
    wr(OFF_PERIOD, 32'h00000008);
    t0 = $time;
    wsync(1);
    // 8 cycles to sync, one edge to see it, then the 1 ns settle
    chk(32'($time - t0), 32'h0000005B);
    wsync(2);
    chk(32'(len), 32'h00000008);
    chkhi(48'h040404040404);
    // status sampled one half apart flips its half bit
    xfer(OFF_STATUS, 1'b0, 32'h00000000);
    r1 = rd;
    repeat (5) @(posedge clk);
    xfer(OFF_STATUS, 1'b0, 32'h00000000);
    chk(32'(rd[0] ^ r1[0]), 32'h00000001);
    chk(32'(rd[1]), 32'h00000001);
    chk(32'(rd[2]), 32'h00000001);
    stop_test;
  end
endmodule
